// *** design/fault_resp_pkg.sv ***
// Types shared by the fault response block.
package fault_resp_pkg;
  typedef struct packed {
    logic wr;
    logic page;
    logic [7:0] code;
    logic [15:0] data;
  } cmd_type;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_OFF = 2'b01,
    ST_WAIT = 2'b10,
    ST_DELAY = 2'b11
  } chan_state_type;
  typedef struct packed {
    logic rq_s1;
    logic rq_s2;
    logic rq_seen;
    logic ack_t;
    logic [15:0] rsp;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] run_d;
    logic [3:0][4:0] resp;
    logic [15:0] retry_raw;
    logic [15:0] delay_ms;
    logic [5:0][7:0] mask;
    logic [1:0][7:0] svout;
    logic [7:0] stemp;
    logic [7:0] sin;
    logic [7:0] scml;
    logic [7:0] svend;
    chan_state_type [1:0] st;
    logic [1:0][16:0] cyc;
    logic [1:0][15:0] ms;
    logic [1:0] en;
    logic alert;
  } sys_state_type;
  typedef struct packed {
    logic busy;
    logic req_t;
    cmd_type hold;
    logic ak_s1;
    logic ak_s2;
    logic ak_seen;
    logic rsp_v;
    logic [15:0] rsp_d;
  } link_state_type;
endpackage

// *** design/fault_resp_regs.svh ***
// Command codes, status bit positions, reset values and timing for the fault response block.
`ifndef FAULT_RESP_REGS_SVH
`define FAULT_RESP_REGS_SVH
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_RESTORE_ALL 8'h16
`define CMD_ALERT_MASK 8'h1B
`define CMD_OT_RESP 8'h50
`define CMD_UT_RESP 8'h54
`define CMD_VIN_OV_RESP 8'h56
`define CMD_TON_MAX_RESP 8'h63
`define CMD_STATUS_BYTE 8'h78
`define CMD_STATUS_WORD 8'h79
`define CMD_STATUS_VOUT 8'h7A
`define CMD_STATUS_IOUT 8'h7B
`define CMD_STATUS_INPUT 8'h7C
`define CMD_STATUS_TEMP 8'h7D
`define CMD_STATUS_CML 8'h7E
`define CMD_STATUS_VENDOR 8'h80
`define CMD_RETRY_DELAY 8'hDB
`define CMD_COMMON_STATUS 8'hE5
`define CMD_PAD_STATUS 8'hE7
`define CMD_SOFT_RESET 8'hFD
`define BIT_TON_MAX 2
`define BIT_OT 7
`define BIT_UT 4
`define BIT_VIN_OV 7
`define BIT_CML_CMD 7
`define BIT_CML_DATA 6
`define BIT_PIN_LOW 0
`define MASK_RST 8'h00
`define MASK_VENDOR_RST 8'h11
`define RESP_RST 8'h80
`define RETRY_RST 16'h0078
`define RETRY_MIN_MS 120
`define RETRY_MAX_MS 32700
`define MS_NS 1000000
`define CLK_NS 10
`endif

// *** design/fault_response_retry_alert_mask.sv ***
// Fault response decode, shutdown and retry timing, and alert masking for two channels.
`timescale 1ns/1ns
`include "fault_resp_regs.svh"
module fault_response_retry_alert_mask #(
  parameter int CYC_PER_MS = `MS_NS / `CLK_NS
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic cmd_valid,
  input wire fault_resp_pkg::cmd_type cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  input wire logic [1:0] ton_max_flt,
  input wire logic vin_ov_flt,
  input wire logic ot_flt,
  input wire logic ut_flt,
  input wire logic [1:0] fault_pin_low,
  input wire logic [1:0] run_on,
  input wire logic [1:0] vout_decayed,
  input wire logic [1:0] decay_skip,
  output logic [1:0] chan_enable,
  output logic alert_out,
  output logic alert_oe
);
  logic rst_ff1, rst_n;
  logic lrst_ff1, lrst_n;
  fault_resp_pkg::sys_state_type s, n;
  fault_resp_pkg::link_state_type l, ln;
  logic exec, clr_all, bad_resp;
  logic [1:0] sd_any, sd_stop;

  // Status-register code to mask slot; bit 3 flags a maskable register.
  function automatic logic [3:0] mask_idx(input logic [7:0] c);
    unique case (c)
      `CMD_STATUS_VOUT: mask_idx = 4'h8;
      `CMD_STATUS_IOUT: mask_idx = 4'h9;
      `CMD_STATUS_TEMP: mask_idx = 4'hA;
      `CMD_STATUS_CML: mask_idx = 4'hB;
      `CMD_STATUS_INPUT: mask_idx = 4'hC;
      `CMD_STATUS_VENDOR: mask_idx = 4'hD;
      default: mask_idx = 4'h0;
    endcase
  endfunction

  // Response command code to slot; bit 2 flags a response command.
  function automatic logic [2:0] resp_idx(input logic [7:0] c);
    unique case (c)
      `CMD_TON_MAX_RESP: resp_idx = 3'h4;
      `CMD_VIN_OV_RESP: resp_idx = 3'h5;
      `CMD_OT_RESP: resp_idx = 3'h6;
      `CMD_UT_RESP: resp_idx = 3'h7;
      default: resp_idx = 3'h0;
    endcase
  endfunction

  // Linear 5/11 word to milliseconds; a negative mantissa yields zero and fails the range.
  function automatic logic [31:0] lin_ms(input logic [15:0] d);
    logic [31:0] m;
    logic [4:0] e;
    m = {21'h000000, d[10:0]};
    e = d[15:11];
    if (d[10]) begin
      lin_ms = 32'h00000000;
    end else if (e[4]) begin
      lin_ms = m >> (~e + 5'h01);
    end else begin
      lin_ms = m << e;
    end
  endfunction

  function automatic logic [7:0] stat_of(input fault_resp_pkg::sys_state_type x,
                                         input logic [2:0] i, input logic pg);
    unique case (i)
      3'h0: stat_of = x.svout[pg];
      3'h2: stat_of = x.stemp;
      3'h3: stat_of = x.scml;
      3'h4: stat_of = x.sin;
      3'h5: stat_of = x.svend;
      default: stat_of = 8'h00;
    endcase
  endfunction

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_ff1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_ff1 <= 1'b1;
      rst_n <= rst_ff1;
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lrst_ff1 <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_ff1 <= 1'b1;
      lrst_n <= lrst_ff1;
    end
  end

  // Link side: one command in flight; the held word stays still until the answer returns.
  always_comb begin
    ln = l;
    ln.rsp_v = 1'b0;
    ln.ak_s1 = s.ack_t;
    ln.ak_s2 = l.ak_s1;
    if (cmd_valid && !l.busy) begin
      ln.hold = cmd;
      ln.req_t = ~l.req_t;
      ln.busy = 1'b1;
    end
    if (l.ak_s2 != l.ak_seen) begin
      ln.ak_seen = l.ak_s2;
      ln.busy = 1'b0;
      ln.rsp_v = 1'b1;
      ln.rsp_d = s.rsp;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      l <= '0;
    end else begin
      l <= ln;
    end
  end

  assign cmd_ready = !l.busy;
  assign rsp_valid = l.rsp_v;
  assign rsp_data = l.rsp_d;

  always_comb begin
    logic [31:0] v;
    logic [3:0] mi;
    logic [2:0] ri;
    logic [1:0] fc;
    logic cml_cmd, cml_data, stop;
    v = 32'h00000000;
    mi = 4'h0;
    ri = 3'h0;
    fc = 2'b00;
    cml_cmd = 1'b0;
    cml_data = 1'b0;
    stop = 1'b0;
    n = s;
    n.rq_s1 = l.req_t;
    n.rq_s2 = s.rq_s1;
    n.pin_s1 = fault_pin_low;
    n.pin_s2 = s.pin_s1;
    n.run_d = run_on;
    exec = s.rq_s2 != s.rq_seen;
    clr_all = 1'b0;
    bad_resp = 1'b0;
    if (exec) begin
      n.rq_seen = s.rq_s2;
      n.ack_t = ~s.ack_t;
      n.rsp = 16'h0000;
      mi = mask_idx(l.hold.code);
      ri = resp_idx(l.hold.code);
      if (ri[2]) begin
        if (l.hold.wr) begin
          if (l.hold.data[7:6] == 2'b01 || l.hold.data[7:6] == 2'b11) begin
            bad_resp = 1'b1;
            cml_data = 1'b1;
          end else begin
            n.resp[ri[1:0]] = l.hold.data[7:3];
          end
        end else begin
          n.rsp = {8'h00, s.resp[ri[1:0]], 3'b000};
        end
      end else if (mi[3]) begin
        if (l.hold.wr) begin
          // Writing ones clears those latched bits; the status pass below still re-sets them.
          unique case (mi[2:0])
            3'h0: n.svout[l.hold.page] = s.svout[l.hold.page] & ~l.hold.data[7:0];
            3'h2: n.stemp = s.stemp & ~l.hold.data[7:0];
            3'h3: n.scml = s.scml & ~l.hold.data[7:0];
            3'h4: n.sin = s.sin & ~l.hold.data[7:0];
            3'h5: n.svend = s.svend & ~l.hold.data[7:0];
            default: n.sin = s.sin;
          endcase
        end else begin
          n.rsp = {8'h00, stat_of(s, mi[2:0], l.hold.page)};
        end
      end else begin
        unique case (l.hold.code)
          `CMD_CLEAR_FAULTS, `CMD_RESTORE_ALL, `CMD_SOFT_RESET: clr_all = l.hold.wr;
          `CMD_STATUS_BYTE: n.rsp = {13'h0000, |s.stemp, |s.scml, 1'b0};
          `CMD_STATUS_WORD: n.rsp = {|s.svout[l.hold.page], 1'b0, |s.sin, |s.svend, 9'h000,
                                     |s.stemp, |s.scml, 1'b0};
          `CMD_ALERT_MASK: begin
            mi = mask_idx(l.hold.data[7:0]);
            if (!mi[3]) begin
              cml_data = 1'b1;
            end else if (l.hold.wr) begin
              n.mask[mi[2:0]] = l.hold.data[15:8];
            end else begin
              n.rsp = {8'h00, s.mask[mi[2:0]]};
            end
          end
          `CMD_RETRY_DELAY: begin
            if (l.hold.wr) begin
              v = lin_ms(l.hold.data);
              if (v >= `RETRY_MIN_MS && v <= `RETRY_MAX_MS) begin
                n.retry_raw = l.hold.data;
                n.delay_ms = v[15:0];
              end else begin
                cml_data = 1'b1;
              end
            end else begin
              n.rsp = s.retry_raw;
            end
          end
          default: cml_cmd = 1'b1;
        endcase
      end
    end
    if (clr_all) begin
      n.svout = '0;
      n.stemp = 8'h00;
      n.sin = 8'h00;
      n.scml = 8'h00;
      n.svend = 8'h00;
    end
    for (int c = 0; c < 2; c++) begin
      if (run_on[c] && !s.run_d[c]) begin
        n.svout[c] = 8'h00;
      end
    end
    // Hardware sets are applied last so that a set always beats a clear in the same cycle.
    for (int c = 0; c < 2; c++) begin
      n.svout[c][`BIT_TON_MAX] = n.svout[c][`BIT_TON_MAX] | ton_max_flt[c];
    end
    n.stemp[`BIT_OT] = n.stemp[`BIT_OT] | ot_flt;
    n.stemp[`BIT_UT] = n.stemp[`BIT_UT] | ut_flt;
    n.sin[`BIT_VIN_OV] = n.sin[`BIT_VIN_OV] | vin_ov_flt;
    n.scml[`BIT_CML_CMD] = n.scml[`BIT_CML_CMD] | cml_cmd;
    n.scml[`BIT_CML_DATA] = n.scml[`BIT_CML_DATA] | cml_data;
    n.svend[`BIT_PIN_LOW] = n.svend[`BIT_PIN_LOW] | (|s.pin_s2);
    for (int c = 0; c < 2; c++) begin
      fc = {ton_max_flt[c], vin_ov_flt};
      // A fault only shuts the channel down when its response top bits are 10.
      sd_any[c] = (fc[1] && s.resp[0][4:3] == 2'b10) ||
                  (fc[0] && s.resp[1][4:3] == 2'b10) ||
                  (ot_flt && s.resp[2][4:3] == 2'b10) ||
                  (ut_flt && s.resp[3][4:3] == 2'b10);
      sd_stop[c] = (fc[1] && s.resp[0][4:3] == 2'b10 && s.resp[0][2:0] != 3'b111) ||
                   (fc[0] && s.resp[1][4:3] == 2'b10 && s.resp[1][2:0] != 3'b111) ||
                   (ot_flt && s.resp[2][4:3] == 2'b10 && s.resp[2][2:0] != 3'b111) ||
                   (ut_flt && s.resp[3][4:3] == 2'b10 && s.resp[3][2:0] != 3'b111);
      stop = !run_on[c];
      unique case (s.st[c])
        fault_resp_pkg::ST_RUN: begin
          if (run_on[c] && sd_any[c]) begin
            n.st[c] = sd_stop[c] ? fault_resp_pkg::ST_OFF : fault_resp_pkg::ST_WAIT;
          end
        end
        fault_resp_pkg::ST_OFF: begin
          if (stop || clr_all) begin
            n.st[c] = fault_resp_pkg::ST_RUN;
          end
        end
        fault_resp_pkg::ST_WAIT: begin
          if (stop) begin
            n.st[c] = fault_resp_pkg::ST_RUN;
          end else if (sd_stop[c]) begin
            n.st[c] = fault_resp_pkg::ST_OFF;
          end else if (!sd_any[c] && !s.pin_s2[c]) begin
            n.st[c] = fault_resp_pkg::ST_DELAY;
            n.cyc[c] = 17'h00000;
            n.ms[c] = 16'h0000;
          end
        end
        fault_resp_pkg::ST_DELAY: begin
          if (stop) begin
            n.st[c] = fault_resp_pkg::ST_RUN;
          end else if (sd_stop[c]) begin
            n.st[c] = fault_resp_pkg::ST_OFF;
          end else if (sd_any[c] || s.pin_s2[c]) begin
            n.st[c] = fault_resp_pkg::ST_WAIT;
          end else begin
            if (s.cyc[c] == 17'(CYC_PER_MS - 1)) begin
              n.cyc[c] = 17'h00000;
              n.ms[c] = (s.ms[c] == 16'hFFFF) ? s.ms[c] : s.ms[c] + 16'h0001;
            end else begin
              n.cyc[c] = s.cyc[c] + 17'h00001;
            end
            if (s.ms[c] >= s.delay_ms && (decay_skip[c] || vout_decayed[c])) begin
              n.st[c] = fault_resp_pkg::ST_RUN;
            end
          end
        end
      endcase
      n.en[c] = run_on[c] && n.st[c] == fault_resp_pkg::ST_RUN;
    end
    n.alert = |(n.svout[0] & ~n.mask[0]) | |(n.svout[1] & ~n.mask[0]) |
              |(n.stemp & ~n.mask[2]) | |(n.scml & ~n.mask[3]) |
              |(n.sin & ~n.mask[4]) | |(n.svend & ~n.mask[5]);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.resp <= {4{5'(`RESP_RST >> 3)}};
      s.retry_raw <= `RETRY_RST;
      // The reset word has a zero exponent, so it is already the count in milliseconds.
      s.delay_ms <= `RETRY_RST;
      s.mask <= {`MASK_VENDOR_RST, {5{`MASK_RST}}};
    end else begin
      s <= n;
    end
  end

  assign chan_enable = s.en;
  assign alert_out = 1'b0;
  assign alert_oe = s.alert;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence retry_left;
    (s.st[0] == fault_resp_pkg::ST_DELAY && run_on[0]) ##1 s.st[0] == fault_resp_pkg::ST_RUN;
  endsequence

  chk_ton_max_set: assert property (ton_max_flt[0] |=> s.svout[0][`BIT_TON_MAX])
    else $error("Rise timeout fault did not set vout status.");
  chk_resp_reject: assert property (
    bad_resp |=> s.scml[`BIT_CML_DATA] && $stable(s.resp))
    else $error("Unsupported response byte was accepted.");
  chk_immediate_off: assert property (
    (s.st[0] == fault_resp_pkg::ST_RUN && run_on[0] && sd_any[0]) |=> !chan_enable[0])
    else $error("Output stayed on after shutdown fault.");
  chk_no_restart: assert property (
    (s.st[0] == fault_resp_pkg::ST_OFF && run_on[0] && !clr_all) |=> !chan_enable[0])
    else $error("Output restarted without clear.");
  chk_delay_start: assert property (
    (s.st[0] == fault_resp_pkg::ST_WAIT && run_on[0] && !sd_any[0] && !sd_stop[0] && !s.pin_s2[0])
    |=> s.st[0] == fault_resp_pkg::ST_DELAY && s.ms[0] == 16'h0000)
    else $error("Delay count did not start after fault cleared.");
  chk_retry_wait: assert property (retry_left |-> $past(s.ms[0]) >= s.delay_ms)
    else $error("Retry came before the programmed delay.");
  chk_temp_alert: assert property ((|(s.stemp & ~s.mask[2])) |-> alert_oe)
    else $error("Unmasked temperature bit without alert.");
  chk_masked_set: assert property (ot_flt |=> s.stemp[`BIT_OT])
    else $error("Temperature fault did not set status.");
endmodule // fault_response_retry_alert_mask

// *** tb/host_link_model.sv ***
// Host side model that offers one command at a time on the command link.
`timescale 1ns/1ns
module host_link_model (
  input wire logic link_clk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  output logic cmd_valid,
  output fault_resp_pkg::cmd_type cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // One command in flight, data bytes packed low byte first.
  task automatic xfer(input fault_resp_pkg::cmd_type c, output logic [15:0] d);
    int n;
    n = 0;
    d = 'x;
    @(negedge link_clk);
    cmd_valid = 1'b1;
    cmd = c;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge link_clk);
      n++;
    end
    @(posedge link_clk);
    @(negedge link_clk);
    cmd_valid = 1'b0;
    // Inverted leftovers keep a stale command from passing for a fresh one.
    cmd = ~c;
    while (rsp_valid !== 1'b1 && n < 100) begin
      @(negedge link_clk);
      n++;
    end
    if (rsp_valid === 1'b1) d = rsp_data;
  endtask
endmodule // host_link_model

// *** tb/test_fault_response_retry_alert_mask.sv ***
// Self-checking bench for the fault response, retry and alert mask block.
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_fault_response_retry_alert_mask;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid;
  fault_resp_pkg::cmd_type cmd;
  logic cmd_ready, rsp_valid, alert_out, alert_oe, vin_ov_flt, ot_flt, ut_flt;
  logic [15:0] rsp_data, last;
  logic [1:0] ton_max_flt, fault_pin_low, run_on, vout_decayed, decay_skip, chan_enable;
  int fails = 0;
  int samples_checked = 0;
  localparam logic [7:0] mask_codes [6] = '{8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80};
  localparam logic [7:0] deny_codes [5] = '{8'h78, 8'h79, 8'hE5, 8'hE7, 8'h99};
  localparam logic [7:0] resp_codes [4] = '{8'h50, 8'h54, 8'h56, 8'h63};

  always #5 sys_clk = ~sys_clk;
  initial begin
    #1;
    forever #3 link_clk = ~link_clk;
  end

  // A short millisecond keeps the 120 ms retry wait at 1200 core cycles.
  fault_response_retry_alert_mask #(.CYC_PER_MS(10)) uut (.sys_clk, .reset_n, .link_clk,
    .cmd_valid, .cmd, .cmd_ready, .rsp_valid, .rsp_data, .ton_max_flt, .vin_ov_flt, .ot_flt,
    .ut_flt, .fault_pin_low, .run_on, .vout_decayed, .decay_skip, .chan_enable, .alert_out,
    .alert_oe);
  host_link_model host (.link_clk, .cmd_ready, .rsp_valid, .rsp_data, .cmd_valid, .cmd);

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d,
                      input logic p = 1'b0);
    fault_resp_pkg::cmd_type k;
    k = '{w, p, c, d};
    host.xfer(k, last);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] d, input logic [15:0] e,
                    input logic p = 1'b0);
    send(1'b0, c, d, p);
    `CHK(last, e)
  endtask
  task automatic clr();
    send(1'b1, 8'h03, 16'h0000);
    cyc(3);
  endtask
  task automatic bad(input logic [7:0] c, input logic [15:0] d);
    send(1'b1, c, d);
    rd(8'h7E, 16'h0000, 16'h0040);
    `CHK(alert_oe, 1'b1)
    clr();
    `CHK(alert_oe, 1'b0)
  endtask
  task automatic hit(input logic [1:0] ch, input int n);
    ton_max_flt = ch;
    cyc(n);
    ton_max_flt = 2'b00;
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    {ton_max_flt, vin_ov_flt, ot_flt, ut_flt, fault_pin_low, decay_skip} = '0;
    run_on = 2'b11;
    vout_decayed = 2'b11;
    cyc(20);
    reset_n = 1'b1;
    cyc(6);
    `CHK(alert_out, 1'b0)
    foreach (mask_codes[i]) begin
      rd(8'h1B, {8'h00, mask_codes[i]}, {8'h00, (i == 5) ? 8'h11 : 8'h00});
    end
    rd(8'hDB, 16'h0000, 16'h0078);
    foreach (deny_codes[i]) bad(8'h1B, {8'h01, deny_codes[i]});
    bad(8'h63, 16'h0040);
    bad(8'h63, 16'h00C0);
    bad(8'hDB, 16'h0077);
    bad(8'hDB, 16'h2BFF);
    bad(8'hDB, 16'h07FF);
    rd(8'hDB, 16'h0000, 16'h0078);
    rd(8'h63, 16'h0000, 16'h0080);
    send(1'b1, 8'h99, 16'h0000);
    rd(8'h7E, 16'h0000, 16'h0080);
    `CHK(alert_oe, 1'b1)
    send(1'b1, 8'hFD, 16'h0000);
    cyc(3);
    `CHK(alert_oe, 1'b0)
    foreach (resp_codes[i]) begin
      send(1'b1, resp_codes[i], 16'h00BF);
      rd(resp_codes[i], 16'h0000, 16'h00B8);
    end
    send(1'b1, 8'hDB, 16'h083C);
    rd(8'hDB, 16'h0000, 16'h083C);
    send(1'b1, 8'h63, 16'h0000);
    hit(2'b01, 3);
    `CHK(chan_enable, 2'b11)
    `CHK(alert_oe, 1'b1)
    rd(8'h7A, 16'h0000, 16'h0004);
    rd(8'h79, 16'h0000, 16'h8000);
    send(1'b1, 8'h7A, 16'h0004);
    rd(8'h7A, 16'h0000, 16'h0000);
    cyc(2);
    `CHK(alert_oe, 1'b0)
    send(1'b1, 8'h1B, 16'h047A);
    rd(8'h1B, 16'h007A, 16'h0004);
    hit(2'b10, 3);
    `CHK(alert_oe, 1'b0)
    rd(8'h7A, 16'h0000, 16'h0004, 1'b1);
    send(1'b1, 8'h1B, 16'h007A);
    cyc(2);
    `CHK(alert_oe, 1'b1)
    send(1'b1, 8'h63, 16'h0080);
    clr();
    hit(2'b01, 2);
    `CHK(chan_enable, 2'b10)
    cyc(1500);
    `CHK(chan_enable, 2'b10)
    clr();
    `CHK(chan_enable, 2'b11)
    hit(2'b01, 2);
    run_on = 2'b10;
    cyc(3);
    run_on = 2'b11;
    cyc(3);
    `CHK(chan_enable, 2'b11)
    rd(8'h7A, 16'h0000, 16'h0000);
    send(1'b1, 8'h63, 16'h00B8);
    repeat (2) begin
      fault_pin_low = 2'b01;
      hit(2'b01, 2);
      cyc(1300);
      `CHK(chan_enable, 2'b10)
      fault_pin_low = 2'b00;
      cyc(1190);
      `CHK(chan_enable, 2'b10)
      cyc(30);
      `CHK(chan_enable, 2'b11)
    end
    vout_decayed = 2'b10;
    hit(2'b01, 2);
    cyc(1300);
    `CHK(chan_enable, 2'b10)
    vout_decayed = 2'b11;
    cyc(3);
    `CHK(chan_enable, 2'b11)
    {vout_decayed, decay_skip} = 4'b1001;
    hit(2'b01, 2);
    cyc(1230);
    `CHK(chan_enable, 2'b11)
    vout_decayed = 2'b11;
    {ot_flt, ut_flt, vin_ov_flt} = 3'b111;
    cyc(2);
    {ot_flt, ut_flt, vin_ov_flt} = 3'b000;
    `CHK(chan_enable, 2'b00)
    rd(8'h7D, 16'h0000, 16'h0090);
    rd(8'h78, 16'h0000, 16'h0004);
    rd(8'h7C, 16'h0000, 16'h0080);
    send(1'b1, 8'h16, 16'h0000);
    cyc(3);
    `CHK(alert_oe, 1'b0)
    complete_run();
  end

  // The full sequence needs about 9600 core cycles; this allows well over twice that.
  initial begin
    #300000;
    fails++;
    complete_run();
  end
endmodule // test_fault_response_retry_alert_mask
